// ### verilog/wlsp_top.sv
// write latch and per-sector protection flags of the serial flash
// Notes on behaviour
// - modifying commands need latch already set
// - opcode 06h sets latch at frame end
// - partial opcode byte leaves latch untouched
// - opcode 04h clears latch at frame end
// - latch-clear also ends sequential program mode
// - all sector flags protected after reset
// - protected sectors reject program and erase
// - 36h plus three address bytes protects sector
// - complete protect sets flag, clears latch
// - 39h plus three address bytes unprotects sector
// - complete unprotect clears flag and latch
// - short address aborts, clears latch only
// - lock flag ignores protect commands, clears latch
// - program/erase into protected sector refused
// - chip erase refused if any sector protected
`timescale 1ns/100ps
module wlsp_top
  import wlsp_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   mosi,
  input  wire logic                   protection_lock_flag,
  output logic                        write_latch_flag,
  output logic [NUM_SECTORS-1:0]      sector_prot,
  output logic                        program_go,
  output logic                        block_erase_go,
  output logic [1:0]                  erase_size,
  output logic                        chip_erase_go,
  output logic                        status_write_go,
  output logic                        seq_mode_exit,
  output logic [ADDR_W-1:0]           op_addr
);

  typedef struct packed
  {
    logic [2:0]             cs_sync;
    logic                   wlf;
    logic [NUM_SECTORS-1:0] prot;
    logic                   prog_go;
    logic                   blk_go;
    logic [1:0]             era;
    logic                   chip_go;
    logic                   stat_go;
    logic                   seq_exit;
    logic [ADDR_W-1:0]      addr;
    logic                   tag_seen;
  } wlsp_core_s;

  wlsp_link_if lnk ();

  wlsp_core_s st_r;
  wlsp_core_s st_nxt;
  logic       frame_end;
  logic [7:0] op;
  logic [2:0] cnt;
  logic       hit_prot;
  logic       fresh;

  wlsp_spi_rx u_rx
  (
    .sclk (sclk),
    .cs_n (cs_n),
    .mosi (mosi),
    .rstn (rstn),
    .lnk  (lnk.link)
  );

  function automatic logic [SECTOR_W-1:0] sector_of(
    input logic [ADDR_W-1:0] a
  );
    sector_of = a[SECTOR_LSB +: SECTOR_W];
  endfunction : sector_of

  function automatic logic is_block_erase(input logic [7:0] o);
    is_block_erase = (o == OP_ERASE_4K) || (o == OP_ERASE_32K) ||
                     (o == OP_ERASE_64K);
  endfunction : is_block_erase

  function automatic logic [1:0] era_kind(input logic [7:0] o);
    unique case (o)
      OP_ERASE_4K:  era_kind = WLSP_ERA_4K;
      OP_ERASE_32K: era_kind = WLSP_ERA_32K;
      default:      era_kind = WLSP_ERA_64K;
    endcase
  endfunction : era_kind

  // the link registers are quiet once cs_n is high; they are read only
  // after the deassertion has passed the two-stage synchroniser
  assign frame_end = st_r.cs_sync[1] & ~st_r.cs_sync[2];
  assign op        = lnk.opcode;
  assign cnt       = lnk.byte_cnt;
  assign hit_prot  = st_r.prot[sector_of(lnk.addr)];
  assign fresh     = (lnk.tag != st_r.tag_seen);

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.cs_sync  = {st_r.cs_sync[1:0], cs_n};
    st_nxt.prog_go  = 1'b0;
    st_nxt.blk_go   = 1'b0;
    st_nxt.chip_go  = 1'b0;
    st_nxt.stat_go  = 1'b0;
    st_nxt.seq_exit = 1'b0;
    if (frame_end)
    begin
      st_nxt.tag_seen = lnk.tag;
    end
    // a frame without any sclk edge must not act on stale link bytes
    if (frame_end && fresh && (cnt >= CNT_OPCODE))
    begin
      if (op == OP_LATCH_SET)
      begin
        st_nxt.wlf = 1'b1;
      end
      else if (op == OP_LATCH_CLR)
      begin
        st_nxt.wlf      = 1'b0;
        st_nxt.seq_exit = 1'b1;
      end
      else if ((op == OP_SECT_PROT) || (op == OP_SECT_UNPROT))
      begin
        st_nxt.wlf = 1'b0;
        if (!protection_lock_flag && st_r.wlf &&
            (cnt >= CNT_ADDRESS))
        begin
          st_nxt.prot[sector_of(lnk.addr)] = (op == OP_SECT_PROT);
        end
      end
      else if (op == OP_PROGRAM)
      begin
        st_nxt.wlf  = 1'b0;
        st_nxt.addr = lnk.addr;
        st_nxt.prog_go = st_r.wlf && (cnt >= CNT_DATA) && !hit_prot;
      end
      else if (is_block_erase(op))
      begin
        st_nxt.wlf  = 1'b0;
        st_nxt.addr = lnk.addr;
        st_nxt.era  = era_kind(op);
        st_nxt.blk_go = st_r.wlf && (cnt >= CNT_ADDRESS) && !hit_prot;
      end
      else if ((op == OP_CHIP_ERA_A) || (op == OP_CHIP_ERA_B))
      begin
        st_nxt.wlf     = 1'b0;
        st_nxt.chip_go = st_r.wlf && !(|st_r.prot);
      end
      else if (op == OP_STATUS_WR)
      begin
        st_nxt.wlf     = 1'b0;
        st_nxt.stat_go = st_r.wlf && (cnt > CNT_OPCODE);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r         <= '0;
      st_r.cs_sync <= 3'h7;
      st_r.wlf     <= WLF_RESET;
      st_r.prot    <= PROT_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign write_latch_flag = st_r.wlf;
  assign sector_prot      = st_r.prot;
  assign program_go       = st_r.prog_go;
  assign block_erase_go   = st_r.blk_go;
  assign erase_size       = st_r.era;
  assign chip_erase_go    = st_r.chip_go;
  assign status_write_go  = st_r.stat_go;
  assign seq_mode_exit    = st_r.seq_exit;
  assign op_addr          = st_r.addr;

endmodule : wlsp_top

// ### verilog/wlsp_pkg.sv
// constants and types shared by the write-latch and sector-protect logic
package wlsp_pkg;

  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR   = 8'h04;
  localparam logic [7:0] OP_SECT_PROT   = 8'h36;
  localparam logic [7:0] OP_SECT_UNPROT = 8'h39;
  localparam logic [7:0] OP_PROGRAM     = 8'h02;
  localparam logic [7:0] OP_ERASE_4K    = 8'h20;
  localparam logic [7:0] OP_ERASE_32K   = 8'h52;
  localparam logic [7:0] OP_ERASE_64K   = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERA_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERA_B  = 8'hC7;
  localparam logic [7:0] OP_STATUS_WR   = 8'h01;

  localparam int         NUM_SECTORS    = 64;
  localparam int         SECTOR_LSB     = 16;
  localparam int         SECTOR_W       = 6;
  localparam int         ADDR_W         = 24;

  // byte counts are of fully received bytes, opcode included
  localparam logic [2:0] CNT_OPCODE     = 3'h1;
  localparam logic [2:0] CNT_ADDRESS    = 3'h4;
  localparam logic [2:0] CNT_DATA       = 3'h5;
  localparam logic [2:0] CNT_MAX        = 3'h7;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  localparam logic                   WLF_RESET  = 1'b0;
  localparam logic [NUM_SECTORS-1:0] PROT_RESET = {NUM_SECTORS{1'b1}};

  typedef enum logic [1:0]
  {
    WLSP_ERA_4K  = 2'b00,
    WLSP_ERA_32K = 2'b01,
    WLSP_ERA_64K = 2'b10
  } wlsp_era_e;

endpackage : wlsp_pkg

// ### verilog/wlsp_link_if.sv
// frame contents handed from the serial-clock side to the system side
`timescale 1ns/100ps
interface wlsp_link_if;
  import wlsp_pkg::*;

  logic [7:0]        opcode;
  logic [ADDR_W-1:0] addr;
  logic [2:0]        byte_cnt;
  logic              tag;

  modport link (output opcode, output addr, output byte_cnt, output tag);
  modport core (input opcode, input addr, input byte_cnt, input tag);
endinterface : wlsp_link_if

// ### verilog/wlsp_spi_rx.sv
// serial-clock side: shifts opcode and address bytes of one frame
`timescale 1ns/100ps
module wlsp_spi_rx
  import wlsp_pkg::*;
(
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic rstn,
  wlsp_link_if.link lnk
);

  typedef struct packed
  {
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        byte_cnt;
    logic [7:0]        shift;
    logic              tag;
  } wlsp_frm_s;

  typedef struct packed
  {
    logic [2:0] bit_cnt;
    logic       first;
  } wlsp_bit_s;

  wlsp_frm_s frm_r;
  wlsp_frm_s frm_nxt;
  wlsp_bit_s bit_r;
  wlsp_bit_s bit_nxt;
  logic      byte_done;
  logic [7:0] byte_val;

  // bit position restarts whenever the frame is closed
  always_comb
  begin
    bit_nxt.bit_cnt = bit_r.bit_cnt + 3'h1;
    bit_nxt.first   = 1'b0;
  end

  always_ff @(posedge sclk or negedge rstn or posedge cs_n)
  begin
    if (!rstn || cs_n)
    begin
      bit_r <= '{bit_cnt: 3'h0, first: 1'b1};
    end
    else
    begin
      bit_r <= bit_nxt;
    end
  end

  // byte count and shift register restart on the first edge of a frame, not on
  // cs_n, so the frame data stays readable after the frame closes
  always_comb
  begin
    frm_nxt   = frm_r;
    byte_val  = {frm_r.shift[6:0], mosi};
    byte_done = (bit_r.bit_cnt == BIT_LAST);
    if (bit_r.first)
    begin
      frm_nxt.byte_cnt = 3'h0;
      // flips once per clocked frame so the core can spot a frame that
      // never clocked and would otherwise replay the previous bytes
      frm_nxt.tag      = ~frm_r.tag;
      byte_val         = {7'h00, mosi};
    end
    frm_nxt.shift = byte_val;
    if (byte_done)
    begin
      if (frm_nxt.byte_cnt == 3'h0)
      begin
        frm_nxt.opcode = byte_val;
      end
      else if (frm_nxt.byte_cnt < CNT_ADDRESS)
      begin
        frm_nxt.addr = {frm_r.addr[ADDR_W-9:0], byte_val};
      end
      if (frm_nxt.byte_cnt != CNT_MAX)
      begin
        frm_nxt.byte_cnt = frm_nxt.byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      frm_r <= '0;
    end
    else
    begin
      frm_r <= frm_nxt;
    end
  end

  assign lnk.opcode   = frm_r.opcode;
  assign lnk.addr     = frm_r.addr;
  assign lnk.byte_cnt = frm_r.byte_cnt;
  assign lnk.tag      = frm_r.tag;

endmodule : wlsp_spi_rx

// ### sim/wlsp_chk.sv
// checker for write latch and sector protection flags
`timescale 1ns/100ps
module wlsp_chk
  import wlsp_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   cs_n,
  input wire logic                   protection_lock_flag,
  input wire logic                   write_latch_flag,
  input wire logic [NUM_SECTORS-1:0] sector_prot,
  input wire logic                   program_go,
  input wire logic                   block_erase_go,
  input wire logic                   chip_erase_go,
  input wire logic                   seq_mode_exit,
  input wire logic [ADDR_W-1:0]      op_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // frame end seen a few edges back, after a long low phase
  sequence s_frame_end;
    $past(cs_n, 2) && !$past(cs_n, 6);
  endsequence
  a_go_needs_latch: assert property
    ((program_go || block_erase_go || chip_erase_go) |->
    $past(write_latch_flag) && !write_latch_flag)
    else $error("go without latch");
  a_prog_unprot: assert property (program_go |->
    !sector_prot[op_addr[SECTOR_LSB +: SECTOR_W]])
    else $error("program into protected sector");
  a_blk_unprot: assert property (block_erase_go |->
    !sector_prot[op_addr[SECTOR_LSB +: SECTOR_W]])
    else $error("block erase into protected sector");
  a_chip_unprot: assert property (chip_erase_go |->
    sector_prot == '0)
    else $error("chip erase with protected sector");
  a_prot_onebit: assert property ($changed(sector_prot) |->
    $onehot(sector_prot ^ $past(sector_prot)))
    else $error("several flags changed");
  a_prot_latch: assert property ($changed(sector_prot) |->
    $past(write_latch_flag) && !write_latch_flag
    && !$past(protection_lock_flag))
    else $error("flag change without latch or under lock");
  a_latch_frame: assert property ($changed(write_latch_flag) |->
    s_frame_end)
    else $error("latch changed outside frame end");
  a_prot_frame: assert property ($changed(sector_prot) |->
    s_frame_end)
    else $error("flag changed outside frame end");
  a_exit_latch: assert property (seq_mode_exit |->
    !write_latch_flag ##1 !seq_mode_exit)
    else $error("bad sequential exit");
endmodule : wlsp_chk
bind wlsp_top wlsp_chk i_wlsp_chk (.clk_sys(clk_sys), .rstn(rstn),
  .cs_n(cs_n), .protection_lock_flag(protection_lock_flag),
  .write_latch_flag(write_latch_flag), .sector_prot(sector_prot),
  .program_go(program_go), .block_erase_go(block_erase_go),
  .chip_erase_go(chip_erase_go),
  .seq_mode_exit(seq_mode_exit), .op_addr(op_addr));

// ### sim/wlsp_host.sv
// spi host model: msb-first frames, clock still between frames
`timescale 1ns/100ps
module wlsp_host
(
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic send(input logic [39:0] bits, input int n);
    // start off the system clock's edges so no pin moves on one
    #1.3 cs_n = 1'b0;
    for (int i = 39; i > 39 - n; i--)
    begin
      mosi = bits[i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    // released line shows no stale data
    mosi = ~mosi;
  endtask : send
endmodule : wlsp_host

// ### sim/wlsp_top_tb.sv
// bench for write latch and sector protection flags
`timescale 1ns/100ps
module wlsp_top_tb;
  import wlsp_pkg::*;
  logic                   clk_sys, rstn, lock, sclk, cs_n, mosi;
  logic                   wlf, pg, ce, sx, be, sw;
  logic [1:0]             es;
  logic [NUM_SECTORS-1:0] prot, ep;
  logic [ADDR_W-1:0]      oa, a;
  int                     n_errors = 0, checked = 0, n_go = 0, n_sx = 0;
  int                     n_be = 0, n_sw = 0;
  wlsp_top i_wlsp_top (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .protection_lock_flag(lock),
    .write_latch_flag(wlf), .sector_prot(prot), .program_go(pg),
    .block_erase_go(be), .erase_size(es), .chip_erase_go(ce),
    .status_write_go(sw), .seq_mode_exit(sx), .op_addr(oa));
  wlsp_host i_wlsp_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    n_go <= n_go + int'(pg) + int'(ce);
    n_sx <= n_sx + int'(sx);
    n_be <= n_be + int'(be);
    n_sw <= n_sw + int'(sw);
  end
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] era_op(input int k);
    era_op = (k == 0) ? OP_ERASE_4K :
             (k == 1) ? OP_ERASE_32K : OP_ERASE_64K;
  endfunction : era_op
  task automatic fr(input logic [7:0] op, input int n);
    i_wlsp_host.send({op, a, 8'hA5}, n);
    repeat (8) @(posedge clk_sys);
  endtask : fr
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    rstn = 1'b0;
    lock = 1'b0;
    a = 24'h050000;
    ep = '1;
    void'($urandom(32'h0C1A));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({wlf, prot}, {1'b0, ep});
    fr(OP_SECT_UNPROT, 32);
    chk({wlf, prot}, {1'b0, ep});
    fr(OP_LATCH_SET, 5);
    chk(wlf, 1'b0);
    fr(OP_LATCH_SET, 16);
    chk(wlf, 1'b1);
    fr(OP_LATCH_CLR, 7);
    chk(wlf, 1'b1);
    fr(OP_LATCH_CLR, 12);
    chk({wlf, 32'(n_sx)}, 33'h1);
    repeat (6)
    begin
      a = 24'($urandom);
      fr(OP_LATCH_SET, 8);
      fr(OP_SECT_UNPROT, 40);
      ep[a[21:16]] = 1'b0;
      chk({wlf, prot}, {1'b0, ep});
    end
    fr(OP_LATCH_SET, 8);
    fr(OP_SECT_PROT, 31);
    chk({wlf, prot}, {1'b0, ep});
    lock <= 1'b1;
    fr(OP_LATCH_SET, 8);
    fr(OP_SECT_PROT, 32);
    chk({wlf, prot}, {1'b0, ep});
    lock <= 1'b0;
    fr(OP_LATCH_SET, 8);
    fr(OP_PROGRAM, 40);
    chk({oa, 32'(n_go)}, {a, 32'h1});
    fr(OP_LATCH_SET, 8);
    fr(OP_SECT_PROT, 40);
    ep[a[21:16]] = 1'b1;
    chk({wlf, prot}, {1'b0, ep});
    fr(OP_LATCH_SET, 8);
    fr(OP_PROGRAM, 40);
    fr(OP_LATCH_SET, 8);
    fr(OP_CHIP_ERA_A, 8);
    chk({wlf, 32'(n_go)}, 33'h1);
    fr(OP_STATUS_WR, 16);
    chk(32'(n_sw), 32'h0);
    fr(OP_LATCH_SET, 8);
    fr(OP_STATUS_WR, 16);
    chk({wlf, 32'(n_sw)}, 33'h1);
    for (int s = 0; s < NUM_SECTORS; s++)
    begin
      a = {2'($urandom), 6'(s), 16'($urandom)};
      fr(OP_LATCH_SET, 8);
      fr(OP_SECT_UNPROT, 32);
    end
    chk(prot, '0);
    for (int k = 0; k < 3; k++)
    begin
      a = 24'($urandom);
      fr(OP_LATCH_SET, 8);
      fr(era_op(k), 32 + 4 * k);
      chk({es, oa, 32'(n_be)}, {2'(k), a, 32'(k + 1)});
    end
    fr(OP_LATCH_SET, 8);
    fr(OP_CHIP_ERA_B, 16);
    chk({wlf, 32'(n_go)}, 33'h2);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ep = '1;
    chk({wlf, prot}, {1'b0, ep});
    fr(OP_LATCH_SET, 8);
    fr(OP_ERASE_64K, 32);
    chk({wlf, 32'(n_be)}, 33'h3);
    print_verdict();
  end
endmodule : wlsp_top_tb
